// File: epw_pkg.sv
package epw_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 64;
  localparam int COL_W = 6;
  localparam int CLK_NS = 25;
  // Strobe low time: well over the 20 ns noise filter and the pulse minimum
  localparam int STROBE_LOW_NS = 100;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
  // Strobe high gap inside a load period: least byte load interval 0.2 us
  localparam int LOAD_GAP_NS = 200;
  localparam int LOAD_GAP_CYC = (LOAD_GAP_NS + CLK_NS - 1) / CLK_NS;
  // Longest byte load interval 150 us, rounded down
  localparam int BYTE_LOAD_INTERVAL_NS = 150000;
  localparam int BYTE_LOAD_INTERVAL_CYC = BYTE_LOAD_INTERVAL_NS / CLK_NS;
  // Nonvolatile write time 5 ms
  localparam int NONVOLATILE_WRITE_TIME_NS = 5000000;
  localparam int NONVOLATILE_WRITE_TIME_CYC =
    NONVOLATILE_WRITE_TIME_NS / CLK_NS;
  // Power-up write lockout 5 ms (a least time, rounded up)
  localparam int LOCKOUT_NS = 5000000;
  localparam int LOCKOUT_CYC = (LOCKOUT_NS + CLK_NS - 1) / CLK_NS;
  // Last load to poll delay 200 ns
  localparam int LAST_LOAD_TO_POLL_DELAY_NS = 200;
  localparam int LAST_LOAD_TO_POLL_DELAY_CYC =
    (LAST_LOAD_TO_POLL_DELAY_NS + CLK_NS - 1) / CLK_NS;
  // Read access and output enable hold, rounded up
  localparam int READ_ACCESS_NS = 150;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int OE_HOLD_NS = 10;
  localparam int OE_HOLD_CYC = (OE_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 24;
  // Unlock patterns: three writes to enable protection, six to disable it
  localparam logic [14:0] UNLOCK_ADDR_A = 15'h5555;
  localparam logic [14:0] UNLOCK_ADDR_B = 15'h2aaa;
  localparam logic [7:0] UNLOCK_DATA_A = 8'haa;
  localparam logic [7:0] UNLOCK_DATA_B = 8'h55;
  localparam logic [7:0] PROT_ENABLE_DATA = 8'ha0;
  localparam logic [7:0] PROT_DISABLE_DATA_A = 8'h80;
  localparam logic [7:0] PROT_DISABLE_DATA_B = 8'h20;
  typedef enum logic [1:0] {
    EPW_OP_READ = 2'h0,
    EPW_OP_LOAD = 2'h1,
    EPW_OP_LOAD_CE = 2'h2
  } epw_op_t;
endpackage

// File: epw_sync.sv
`timescale 1ns/100ps
module epw_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// File: epw_host.sv
`timescale 1ns/100ps
module epw_host #(
  parameter int BYTE_LOAD_CYC = epw_pkg::BYTE_LOAD_INTERVAL_CYC,
  parameter int WRITE_TIME_CYC = epw_pkg::NONVOLATILE_WRITE_TIME_CYC,
  parameter int LOCKOUT_CYC = epw_pkg::LOCKOUT_CYC
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  // User side
  input wire logic req_valid_in,
  input wire logic [1:0] req_op_in,
  input wire logic [14:0] req_addr_in,
  input wire logic [7:0] req_data_in,
  input wire logic req_last_in,
  input wire logic prot_enable_in,
  input wire logic prot_disable_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out,
  output logic write_busy_out,
  // Device pins
  output logic [14:0] mem_addr_out,
  output logic mem_chip_sel_n_out,
  output logic mem_out_en_n_out,
  output logic mem_write_n_out,
  output logic [7:0] mem_data_out,
  output logic mem_data_oe_out,
  input wire logic [7:0] mem_data_in
);
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_LOW = 8'h02,
    ST_GAP = 8'h04,
    ST_WAIT_LOAD = 8'h08,
    ST_RD_ACC = 8'h10,
    ST_RD_END = 8'h20,
    ST_POLL = 8'h40,
    ST_LOCK = 8'h80
  } epw_st_t;

  epw_st_t state_r;
  logic [epw_pkg::CNT_W-1:0] cnt_r;
  logic [7:0] rd_sync;
  logic [7:0] poll_prev_r;
  logic poll_first_r;
  logic [2:0] cmd_idx_r;
  logic [2:0] cmd_len_r;
  logic cmd_mode_r;
  logic use_ce_r;
  logic user_last_r;
  logic [7:0] last_data_r;
  logic [3:0] poll_ph_r;
  localparam logic [3:0] POLL_SAMPLE = 4'(epw_pkg::READ_ACCESS_CYC + 2);

  epw_sync #(.WIDTH(8)) u_rd_sync (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .async_in(mem_data_in),
    .sync_out(rd_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Unlock command table: up to six writes
  function automatic logic [22:0] cmd_word(input logic dis,
                                           input logic [2:0] i);
    logic [14:0] a;
    logic [7:0] d;
    a = (i == 3'h1 || i == 3'h4) ? epw_pkg::UNLOCK_ADDR_B
                                 : epw_pkg::UNLOCK_ADDR_A;
    d = (i == 3'h1 || i == 3'h4) ? epw_pkg::UNLOCK_DATA_B
                                 : epw_pkg::UNLOCK_DATA_A;
    if (i == 3'h2) begin
      d = dis ? epw_pkg::PROT_DISABLE_DATA_A : epw_pkg::PROT_ENABLE_DATA;
    end
    if (i == 3'h5) begin
      d = epw_pkg::PROT_DISABLE_DATA_B;
    end
    return {a, d};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Main sequencer
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      state_r <= ST_LOCK;
      cnt_r <= '0;
      mem_addr_out <= '0;
      mem_data_out <= '0;
      mem_data_oe_out <= 1'b0;
      mem_chip_sel_n_out <= 1'b1;
      mem_out_en_n_out <= 1'b1;
      mem_write_n_out <= 1'b1;
      req_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_data_out <= '0;
      write_busy_out <= 1'b1;
      poll_prev_r <= '0;
      poll_first_r <= 1'b0;
      cmd_idx_r <= '0;
      cmd_len_r <= '0;
      cmd_mode_r <= 1'b0;
      use_ce_r <= 1'b0;
      user_last_r <= 1'b0;
      last_data_r <= '0;
      poll_ph_r <= '0;
    end else begin
      rsp_valid_out <= 1'b0;
      unique case (state_r)
        ST_LOCK: begin
          // Hold strobes high through the device's power-up lockout
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r >= epw_pkg::CNT_W'(LOCKOUT_CYC)) begin
            state_r <= ST_IDLE;
            req_ready_out <= 1'b1;
            write_busy_out <= 1'b0;
            cnt_r <= '0;
          end
        end
        ST_IDLE: begin
          cnt_r <= '0;
          if (prot_enable_in || prot_disable_in) begin
            // Enable arms with the following data load; disable stands alone
            cmd_mode_r <= 1'b1;
            cmd_idx_r <= '0;
            cmd_len_r <= prot_disable_in ? 3'h6 : 3'h3;
            use_ce_r <= 1'b0;
            {mem_addr_out, mem_data_out} <= cmd_word(prot_disable_in, 3'h0);
            mem_out_en_n_out <= 1'b1;
            mem_chip_sel_n_out <= 1'b0;
            mem_write_n_out <= 1'b0;
            mem_data_oe_out <= 1'b1;
            req_ready_out <= 1'b0;
            write_busy_out <= 1'b1;
            state_r <= ST_LOW;
          end else if (req_valid_in &&
                       req_op_in == 2'(epw_pkg::EPW_OP_READ)) begin
            mem_addr_out <= req_addr_in;
            mem_data_oe_out <= 1'b0;
            mem_chip_sel_n_out <= 1'b0;
            mem_out_en_n_out <= 1'b0;
            mem_write_n_out <= 1'b1;
            req_ready_out <= 1'b0;
            state_r <= ST_RD_ACC;
          end else if (req_valid_in) begin
            // Address and strobe change on the same edge; OE high blocks nothing
            cmd_mode_r <= 1'b0;
            use_ce_r <= (req_op_in == 2'(epw_pkg::EPW_OP_LOAD_CE));
            user_last_r <= req_last_in;
            mem_addr_out <= req_addr_in;
            mem_data_out <= req_data_in;
            last_data_r <= req_data_in;
            mem_data_oe_out <= 1'b1;
            mem_out_en_n_out <= 1'b1;
            if (req_op_in == 2'(epw_pkg::EPW_OP_LOAD_CE)) begin
              mem_write_n_out <= 1'b0;
              mem_chip_sel_n_out <= 1'b0;
            end else begin
              mem_chip_sel_n_out <= 1'b0;
              mem_write_n_out <= 1'b0;
            end
            req_ready_out <= 1'b0;
            write_busy_out <= 1'b1;
            state_r <= ST_LOW;
          end
        end
        ST_LOW: begin
          // Long enough to pass the noise filter
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r + 1'b1 >= epw_pkg::CNT_W'(epw_pkg::STROBE_LOW_CYC)) begin
            cnt_r <= '0;
            if (use_ce_r) begin
              mem_chip_sel_n_out <= 1'b1;
            end else begin
              mem_write_n_out <= 1'b1;
            end
            state_r <= ST_GAP;
          end
        end
        ST_GAP: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r + 1'b1 >= epw_pkg::CNT_W'(epw_pkg::LOAD_GAP_CYC)) begin
            cnt_r <= '0;
            mem_write_n_out <= 1'b1;
            mem_chip_sel_n_out <= 1'b1;
            mem_data_oe_out <= 1'b0;
            if (cmd_mode_r && cmd_idx_r + 3'h1 < cmd_len_r) begin
              // Next command write within the load interval
              cmd_idx_r <= cmd_idx_r + 3'h1;
              {mem_addr_out, mem_data_out} <=
                cmd_word(cmd_len_r == 3'h6, cmd_idx_r + 3'h1);
              mem_write_n_out <= 1'b0;
              mem_chip_sel_n_out <= 1'b0;
              mem_data_oe_out <= 1'b1;
              state_r <= ST_LOW;
            end else if (cmd_mode_r && cmd_len_r == 3'h3) begin
              // Enable: the next user load follows at once
              cmd_mode_r <= 1'b0;
              req_ready_out <= 1'b1;
              state_r <= ST_IDLE;
            end else if (cmd_mode_r || user_last_r) begin
              state_r <= ST_WAIT_LOAD;
            end else begin
              // More bytes of this page: user must keep within the interval
              req_ready_out <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
        end
        ST_WAIT_LOAD: begin
          // Strobes stay high until the load timer expires
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r + 1'b1 >= epw_pkg::CNT_W'(BYTE_LOAD_CYC)) begin
            cnt_r <= '0;
            poll_first_r <= 1'b1;
            poll_ph_r <= '0;
            mem_chip_sel_n_out <= 1'b0;
            mem_out_en_n_out <= 1'b0;
            state_r <= ST_POLL;
          end
        end
        ST_POLL: begin
          // cnt_r bounds the whole wait; poll_ph_r paces one read each
          cnt_r <= cnt_r + 1'b1;
          poll_ph_r <= poll_ph_r + 4'h1;
          if (poll_ph_r == POLL_SAMPLE) begin
            // Output enable goes high between reads so bit 6 can toggle
            poll_prev_r <= rd_sync;
            poll_first_r <= 1'b0;
            mem_out_en_n_out <= 1'b1;
            if ((!poll_first_r && rd_sync[6] == poll_prev_r[6] &&
                 rd_sync[7] == last_data_r[7]) ||
                cnt_r >= epw_pkg::CNT_W'(WRITE_TIME_CYC)) begin
              mem_chip_sel_n_out <= 1'b1;
              write_busy_out <= 1'b0;
              req_ready_out <= 1'b1;
              cnt_r <= '0;
              poll_ph_r <= '0;
              state_r <= ST_IDLE;
            end
          end else if (poll_ph_r > POLL_SAMPLE) begin
            poll_ph_r <= '0;
            mem_out_en_n_out <= 1'b0;
          end
        end
        ST_RD_ACC: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r + 1'b1 >=
              epw_pkg::CNT_W'(epw_pkg::READ_ACCESS_CYC + 2)) begin
            // Two extra cycles cover the input synchroniser
            rsp_data_out <= rd_sync;
            rsp_valid_out <= 1'b1;
            mem_out_en_n_out <= 1'b1;
            mem_chip_sel_n_out <= 1'b1;
            cnt_r <= '0;
            state_r <= ST_RD_END;
          end
        end
        ST_RD_END: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r + 1'b1 >= epw_pkg::CNT_W'(epw_pkg::OE_HOLD_CYC)) begin
            cnt_r <= '0;
            req_ready_out <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// File: epw_host_monitor.sv
`timescale 1ns/100ps
module epw_host_monitor (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic req_valid_in,
  input wire logic [1:0] req_op_in,
  input wire logic prot_enable_in,
  input wire logic prot_disable_in,
  input wire logic req_ready_out,
  input wire logic rsp_valid_out,
  input wire logic write_busy_out,
  input wire logic [14:0] mem_addr_out,
  input wire logic mem_chip_sel_n_out,
  input wire logic mem_out_en_n_out,
  input wire logic mem_write_n_out,
  input wire logic [7:0] mem_data_out,
  input wire logic mem_data_oe_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  logic take;
  logic strb;
  assign take = req_valid_in && req_ready_out && !prot_enable_in &&
    !prot_disable_in;
  assign strb = !mem_write_n_out && !mem_chip_sel_n_out;
  property p_load_start;
    take && req_op_in == 2'h1 |=> strb && mem_out_en_n_out;
  endproperty
  a_load_start: assert property (p_load_start) else $error("no strobe");
  property p_strobe_oe;
    !mem_write_n_out |-> mem_out_en_n_out;
  endproperty
  a_strobe_oe: assert property (p_strobe_oe) else $error("oe low");
  // Four cycles keeps the pulse far above the noise filter width
  property p_strobe_width;
    $rose(strb) |-> strb [*4] ##1 !strb;
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("width");
  property p_strobe_gap;
    $fell(strb) |-> !strb [*8];
  endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("gap");
  property p_hold;
    strb && $past(strb) |-> $stable(mem_addr_out) && $stable(mem_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("moved in strobe");
  property p_no_fight;
    mem_data_oe_out |-> mem_out_en_n_out;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("contention");
  property p_read_pins;
    !mem_out_en_n_out |-> mem_write_n_out && !mem_chip_sel_n_out;
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("read pins");
  property p_read_rsp;
    take && req_op_in == 2'h0 |-> ##[8:9] rsp_valid_out;
  endproperty
  a_read_rsp: assert property (p_read_rsp) else $error("no answer");
  property p_rsp_cause;
    rsp_valid_out |-> !$past(mem_out_en_n_out);
  endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("no read");
  property p_busy;
    take && req_op_in != 2'h0 |-> ##[1:2] write_busy_out;
  endproperty
  a_busy: assert property (p_busy) else $error("not busy");
endmodule
bind epw_host epw_host_monitor u_mon (.clock_in(clock_in),
  .reset_n_in(reset_n_in), .req_valid_in(req_valid_in),
  .req_op_in(req_op_in), .prot_enable_in(prot_enable_in),
  .prot_disable_in(prot_disable_in), .req_ready_out(req_ready_out),
  .rsp_valid_out(rsp_valid_out), .write_busy_out(write_busy_out),
  .mem_addr_out(mem_addr_out), .mem_chip_sel_n_out(mem_chip_sel_n_out),
  .mem_out_en_n_out(mem_out_en_n_out), .mem_write_n_out(mem_write_n_out),
  .mem_data_out(mem_data_out), .mem_data_oe_out(mem_data_oe_out));

// File: epw_mem_model.sv
`timescale 1ns/100ps
module epw_mem_model #(
  parameter int BLC = 30,
  parameter int WTC = 50,
  parameter int LOCK = 30
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [14:0] addr_in,
  input wire logic cs_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out
);
  typedef struct packed {logic [14:0] a; logic [7:0] d;} epw_ent_t;
  localparam epw_ent_t SEQ [6] = '{{15'h5555, 8'haa}, {15'h2aaa, 8'h55},
    {15'h5555, 8'h00}, {15'h5555, 8'haa}, {15'h2aaa, 8'h55},
    {15'h5555, 8'h20}};
  logic [7:0] mem [0:32767];
  epw_ent_t q[$];
  logic armed = 1'b0;
  logic strb_r = 1'b0;
  logic rd_r = 1'b0;
  logic tog = 1'b0;
  logic [14:0] la = 15'h0;
  logic [7:0] last = 8'h0;
  logic [7:0] drv = 8'h0;
  int tmr = 0;
  int busy = 0;
  int lock = 0;
  wire strb = !cs_n_in && !we_n_in && oe_n_in;
  wire rd = !cs_n_in && !oe_n_in && we_n_in;
  initial for (int i = 0; i < 32768; i++) mem[i] = 8'hff;
  ////////////////////////////////////////
  function automatic bit pre(input int k, input logic [7:0] d2);
    pre = q.size() >= k;
    for (int i = 0; i < k && pre; i++)
      pre = (i == 2) ? q[i] == {15'h5555, d2} : q[i] == SEQ[i];
  endfunction
  task automatic commit();
    int n;
    n = armed ? -1 : 0;
    if (pre(6, 8'h80)) begin
      armed <= 1'b0;
      n = -1;
    end else if (pre(3, 8'ha0)) begin
      armed <= 1'b1;
      n = 3;
    end
    if (n >= 0)
      for (int i = n; i < q.size(); i++)
        mem[{q[q.size()-1].a[14:6], q[i].a[5:0]}] = q[i].d;
    q.delete();
  endtask
  // Armed state is never reset: it must outlive power cycles
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      lock <= LOCK;
      tmr <= 0;
      busy <= 0;
      q.delete();
    end else begin
      if (lock > 0) lock <= lock - 1;
      if (busy > 0) busy <= busy - 1;
      if (rd_r && !rd && (busy > 0 || tmr > 0)) tog <= !tog;
      if (strb && !strb_r) begin
        la <= addr_in;
        tmr <= 0;
      end else if (!strb && strb_r && lock == 0 && busy == 0) begin
        q.push_back({la, data_in});
        last <= data_in;
        tmr <= BLC;
      end else if (tmr == 1) begin
        commit();
        busy <= WTC;
        tmr <= 0;
      end else if (tmr > 1) tmr <= tmr - 1;
    end
    strb_r <= strb;
    rd_r <= rd;
    if (rd) drv <= data_out;
  end
  // Released pins show the inverse so a stale value never passes
  always @* begin
    if (!rd) data_out = ~drv;
    // Polling data shows from the last load on, not only once writing
    else if (busy > 0 || tmr > 0)
      data_out = {~last[7], tog, last[5:0]};
    else data_out = mem[addr_in];
  end
endmodule

// File: epw_host_tb_top.sv
`timescale 1ns/100ps
module epw_host_tb_top;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic req_last_in = 1'b0;
  logic prot_enable_in = 1'b0;
  logic prot_disable_in = 1'b0;
  logic [1:0] req_op_in = 2'h0;
  logic [14:0] req_addr_in = 15'h0;
  logic [7:0] req_data_in = 8'h0;
  logic req_ready_out, rsp_valid_out, write_busy_out, mem_data_oe_out;
  logic mem_chip_sel_n_out, mem_out_en_n_out, mem_write_n_out;
  logic [7:0] rsp_data_out, mem_data_out, dq;
  logic [14:0] mem_addr_out;
  wire logic [7:0] mem_data_in = mem_data_oe_out ? mem_data_out : dq;
  logic [7:0] shadow [0:32767];
  int errors = 0;
  int n_checks = 0;
  always #12.5 clock_in = ~clock_in;
  epw_host #(.BYTE_LOAD_CYC(40), .WRITE_TIME_CYC(60), .LOCKOUT_CYC(30)) uut (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .req_valid_in(req_valid_in),
    .req_op_in(req_op_in), .req_addr_in(req_addr_in),
    .req_data_in(req_data_in), .req_last_in(req_last_in),
    .prot_enable_in(prot_enable_in), .prot_disable_in(prot_disable_in),
    .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_data_out(rsp_data_out), .write_busy_out(write_busy_out),
    .mem_addr_out(mem_addr_out), .mem_chip_sel_n_out(mem_chip_sel_n_out),
    .mem_out_en_n_out(mem_out_en_n_out), .mem_write_n_out(mem_write_n_out),
    .mem_data_out(mem_data_out), .mem_data_oe_out(mem_data_oe_out),
    .mem_data_in(mem_data_in));
  // Device timeout shorter than the host's wait, so polls see the write
  epw_mem_model u_mem (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(mem_addr_out),
    .cs_n_in(mem_chip_sel_n_out), .oe_n_in(mem_out_en_n_out),
    .we_n_in(mem_write_n_out), .data_in(mem_data_in), .data_out(dq));
  ////////////////////////////////////////
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic go(input int p, input logic [1:0] op, input logic [14:0] a,
    input logic [7:0] d, input logic l, output logic [7:0] r);
    int k;
    r = 8'hxx;
    {prot_disable_in, prot_enable_in} = 2'(p);
    req_valid_in = (p == 0);
    req_op_in = op;
    req_addr_in = a;
    req_data_in = d;
    req_last_in = l;
    k = 0;
    do begin
      @(posedge clock_in);
      k++;
    end while (req_ready_out !== 1'b1 && k < 20000);
    if (k >= 20000) errors++;
    #2;
    {prot_disable_in, prot_enable_in, req_valid_in} = 3'h0;
    k = 0;
    do begin
      @(posedge clock_in);
      #2;
      k++;
      if (rsp_valid_out === 1'b1) r = rsp_data_out;
    end while (req_ready_out !== 1'b1 && k < 20000);
    if (k >= 20000) errors++;
  endtask
  task automatic rd_chk(input logic [14:0] a);
    logic [7:0] r;
    go(0, 2'h0, a, 8'h0, 1'b0, r);
    chk(r, shadow[a]);
  endtask
  initial begin
    logic [7:0] r;
    logic [8:0] pg;
    logic [14:0] ad [64];
    logic [7:0] dt [64];
    int n;
    for (int i = 0; i < 32768; i++) shadow[i] = 8'hff;
    void'($urandom(32'hdda38b20));
    repeat (8) @(posedge clock_in);
    #2 reset_n_in = 1'b1;
    for (int rep = 0; rep < 3; rep++) begin
      n = (rep == 0) ? 64 : (rep == 1) ? $urandom_range(2, 6) : 1;
      pg = 9'($urandom_range(0, 510));
      for (int i = 0; i < n; i++) begin
        ad[i] = {(i == n - 1) ? pg + 9'h1 : pg, (rep == 0) ? 6'(i) :
          6'($urandom)};
        if (rep == 1 && i == n - 1) ad[i][5:0] = ad[0][5:0];
        dt[i] = 8'($urandom);
        go(0, (rep == 1) ? 2'h2 : 2'h1, ad[i], dt[i], i == n - 1, r);
      end
      for (int i = 0; i < n; i++) shadow[{pg + 9'h1, ad[i][5:0]}] = dt[i];
      chk({7'h0, write_busy_out}, 8'h0);
      for (int i = 0; i < n; i++) rd_chk({pg + 9'h1, ad[i][5:0]});
      rd_chk({pg, ad[0][5:0]});
      rd_chk({pg + 9'h1, ad[0][5:0] ^ 6'h1});
    end
    for (int i = 0; i < 3; i++) begin
      ad[i] = 15'($urandom) & 15'h0fff;
      dt[i] = 8'($urandom);
      if (i == 1) begin
        // A power cycle in mid-run must leave protection armed
        reset_n_in = 1'b0;
        repeat (8) @(posedge clock_in);
        #2 reset_n_in = 1'b1;
      end
      if (i != 1) go((i == 0) ? 1 : 2, 2'h1, 15'h0, 8'h0, 1'b0, r);
      go(0, 2'h1, ad[i], dt[i], 1'b1, r);
      if (i != 1) shadow[ad[i]] = dt[i];
      rd_chk(ad[i]);
    end
    wrap_up();
  end
  initial begin
    #1000000;
    errors++;
    wrap_up();
  end
endmodule
